/* File: sccec_map.vh */
// Register indices, field positions, reset values and ETU timing counts
// for the smart card character and error control block.
// Assumes it is included by bare name from the design file.
`ifndef SCCEC_MAP_VH
`define SCCEC_MAP_VH

// Register indices; the byte address on APB is four times the index.
`define SCCEC_IDX_CLKDIV     16'hFE10
`define SCCEC_IDX_PARCTL     16'hFE11
`define SCCEC_IDX_CHRCTL     16'hFE12
`define SCCEC_IDX_MODE       16'hFE20
`define SCCEC_IDX_STATUS     16'hFE21

// Reset values.
`define SCCEC_RST_CLKDIV     8'h0C
`define SCCEC_RST_PARCTL     8'h00
`define SCCEC_RST_CHRCTL     8'h2C
`define SCCEC_RST_MODE       8'h00

// parity_control fields.
`define SCCEC_PC_CHK_DIS     6
`define SCCEC_PC_BRK_TX_DIS  5
`define SCCEC_PC_BRK_RX_DIS  4
`define SCCEC_PC_RESEND      3
`define SCCEC_PC_DISCARD     2
`define SCCEC_PC_INJECT      1
`define SCCEC_PC_FORCE       0

// character_control fields.
`define SCCEC_CC_DETECT      6
`define SCCEC_CC_DIRECT      5
`define SCCEC_CC_DUR_HI      4
`define SCCEC_CC_DUR_LO      3

// mode_control and status fields.
`define SCCEC_MD_T1          0
`define SCCEC_ST_BRK_ACTIVE  0
`define SCCEC_ST_PAR_ERR     1
`define SCCEC_ST_CARD_BRK    2

// Direct convention character as it arrives on the line.
`define SCCEC_TS_DIRECT      8'h3B

// ETU timing in half-ETU steps: 10.5 ETU, 11 ETU and break lengths.
`define SCCEC_HALF_BRK_AT    5'h15
`define SCCEC_HALF_SAMPLE_AT 5'h16
`define SCCEC_HALF_DUR_1     3'h2
`define SCCEC_HALF_DUR_1P5   3'h3
`define SCCEC_HALF_DUR_2     3'h4

`endif

/* File: sccec_top.v */
// Smart card character control: card clock divider, parity and break
// handling for T=0, and convention character detection, behind APB.
// Assumes the receiver, transmitter and ETU divider run on clk_sys and
// hand over one-cycle pulses; only the card I/O pin is asynchronous.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sccec_map.vh"

// Summary of operation
// - Master clock divided by select plus one, then by two for card clock.
// - Clock select resets to twelve, a ratio of thirteen.
// - New clock select value is applied only at a divider wrap.
// - Clock select zero behaves exactly like one.
// - Parity settings are shared by both card interfaces.
// - Even parity checked on every received character unless disabled.
// - T=0 parity failure with break generation enabled signals a Break.
// - T=0 with break detection enabled detects a card Break after transmit.
// - T=0 retransmit set resends the last character on a card Break.
// - T=0 discard set drops a received character that fails parity.
// - Inject bit sends odd parity on every transmitted character.
// - Force bit flags a parity error on every received character.
// - Error Break starts 10.5 ETU after the start bit edge.
// - Card Break is sampled 11 ETU after the start bit edge.
// - Break length select gives 1, 1.5 or 2 ETU.
// - Detect bit marks next character as convention, cleared by hardware.
// - Convention character is decoded then stored in the receive FIFO.
// - Convention flag set for direct, cleared for indirect, direct default.
// - Protocol mode bit zero means T=0, one means T=1.
module sccec_top #(
  parameter ADDR_W = 20
) (
  input  wire              clk_sys,
  input  wire              arst_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              etu_half_tick,
  input  wire              rx_start,
  input  wire              rx_done,
  input  wire [7:0]        rx_data,
  input  wire              rx_parity,
  input  wire              tx_start,
  input  wire [7:0]        tx_data,
  output reg               tx_parity,
  output reg               tx_resend,
  output reg               rx_fifo_wr,
  output reg  [7:0]        rx_fifo_data,
  output reg               card_clk,
  output reg               etu_div_tick,
  output reg               convention_direct,
  input  wire              io_in,
  output reg               io_out,
  output reg               io_oe
);

  // Register storage.
  reg  [5:0] ext_clock_select_q;
  reg  [6:0] parity_control_q;
  reg        detect_convention_char_q;
  reg        convention_direct_flag_q;
  reg  [1:0] break_length_select_q;
  reg        protocol_mode_select_q;

  // Reset patterns as whole bytes; each register takes only its own slice
  // so that no load drops bits silently.
  localparam [7:0] CLK_RST  = `SCCEC_RST_CLKDIV;
  localparam [7:0] PAR_RST  = `SCCEC_RST_PARCTL;
  localparam [7:0] CHR_RST  = `SCCEC_RST_CHRCTL;
  localparam [7:0] MODE_RST = `SCCEC_RST_MODE;

  // Divider state.
  reg  [5:0] div_cnt_q;
  reg  [5:0] div_lim_q;
  wire [5:0] div_lim_new;

  // Character timing state.
  reg        busy_q;
  reg        dir_tx_q;
  reg  [4:0] half_cnt_q;
  reg        err_pend_q;
  reg        brk_q;
  reg  [2:0] brk_cnt_q;
  reg        par_err_q;
  reg        card_brk_q;
  reg        io_meta_q;
  reg        io_sync_q;

  // APB decode.
  wire        acc_go;
  wire        wr_go;
  wire [15:0] idx;
  wire        hit;
  reg  [31:0] rd_val;

  // Receive qualifiers.
  wire chk_en;
  wire is_t0;
  wire rx_bad;
  wire rx_err;
  wire half_step;
  wire brk_point;
  wire smp_point;
  reg  [2:0] brk_len;

  // T=0 error handling switches.
  wire brk_gen_en;
  wire brk_det_en;
  wire discard_en;
  wire resend_en;

  assign acc_go = psel & penable & ~pready;
  assign wr_go  = psel & penable & pready & pwrite & ~pslverr;
  assign idx    = paddr[17:2];
  assign hit    = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:18] == {(ADDR_W-18){1'b0}}) &&
                  (idx == `SCCEC_IDX_CLKDIV || idx == `SCCEC_IDX_PARCTL ||
                   idx == `SCCEC_IDX_CHRCTL || idx == `SCCEC_IDX_MODE ||
                   idx == `SCCEC_IDX_STATUS);

  // one shared setting set for both cards.
  assign chk_en    = ~parity_control_q[`SCCEC_PC_CHK_DIS];
  assign is_t0     = ~protocol_mode_select_q;
  // even parity over data and parity bit.
  assign rx_bad    = ^{rx_data, rx_parity};
  // forced error flags regardless of line parity.
  assign rx_err    = parity_control_q[`SCCEC_PC_FORCE] | (chk_en & rx_bad);
  assign half_step = busy_q & etu_half_tick;
  assign brk_point = half_step & ~dir_tx_q & (half_cnt_q == `SCCEC_HALF_BRK_AT - 5'h1);
  assign smp_point = half_step & dir_tx_q & (half_cnt_q == `SCCEC_HALF_SAMPLE_AT - 5'h1);
  // break generation needs T=0 and checking.
  assign brk_gen_en = is_t0 & chk_en & ~parity_control_q[`SCCEC_PC_BRK_TX_DIS];
  assign brk_det_en = is_t0 & ~parity_control_q[`SCCEC_PC_BRK_RX_DIS];
  assign discard_en = is_t0 & chk_en & parity_control_q[`SCCEC_PC_DISCARD];
  assign resend_en  = brk_det_en & parity_control_q[`SCCEC_PC_RESEND];

  assign div_lim_new = (ext_clock_select_q == 6'h00) ? 6'h01 : ext_clock_select_q;

  // break length in half ETUs; the reserved code falls back to 2 ETU.
  always @* begin
    case (break_length_select_q)
      2'h0:    brk_len = `SCCEC_HALF_DUR_1;
      2'h1:    brk_len = `SCCEC_HALF_DUR_1P5;
      2'h2:    brk_len = `SCCEC_HALF_DUR_2;
      default: brk_len = `SCCEC_HALF_DUR_2;
    endcase
  end

  always @* begin
    rd_val = 32'h00000000;
    case (idx)
      `SCCEC_IDX_CLKDIV: rd_val[5:0] = ext_clock_select_q;
      `SCCEC_IDX_PARCTL: rd_val[6:0] = parity_control_q;
      // Reserved low bits read back their reset pattern.
      `SCCEC_IDX_CHRCTL: rd_val[7:0] = {1'b0, detect_convention_char_q,
                                        convention_direct_flag_q,
                                        break_length_select_q, CHR_RST[2:0]};
      `SCCEC_IDX_MODE:   rd_val[`SCCEC_MD_T1] = protocol_mode_select_q;
      `SCCEC_IDX_STATUS: rd_val[2:0] = {card_brk_q, par_err_q, brk_q};
      default:           rd_val = 32'h00000000;
    endcase
  end

  // One wait state: read data and the answer are registered so every
  // port comes from a flip-flop.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (acc_go) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= (hit && !pwrite) ? rd_val : 32'h00000000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-writable configuration.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_clock_select_q     <= CLK_RST[5:0];
      parity_control_q       <= PAR_RST[6:0];
      break_length_select_q  <= CHR_RST[`SCCEC_CC_DUR_HI:`SCCEC_CC_DUR_LO];
      protocol_mode_select_q <= MODE_RST[`SCCEC_MD_T1];
    end else if (wr_go) begin
      if (idx == `SCCEC_IDX_CLKDIV) begin
        ext_clock_select_q <= pwdata[5:0];
      end
      if (idx == `SCCEC_IDX_PARCTL) begin
        parity_control_q <= pwdata[6:0];
      end
      if (idx == `SCCEC_IDX_CHRCTL) begin
        break_length_select_q <= pwdata[`SCCEC_CC_DUR_HI:`SCCEC_CC_DUR_LO];
      end
      if (idx == `SCCEC_IDX_MODE) begin
        protocol_mode_select_q <= pwdata[`SCCEC_MD_T1];
      end
    end
  end

  // Detect and direct bits: the hardware update wins over a software
  // write in the same cycle so the convention result is never lost.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      detect_convention_char_q <= CHR_RST[`SCCEC_CC_DETECT];
      convention_direct_flag_q <= CHR_RST[`SCCEC_CC_DIRECT];
    end else if (rx_done && detect_convention_char_q) begin
      // decode and clear the detect bit.
      detect_convention_char_q <= 1'b0;
      convention_direct_flag_q <= (rx_data == `SCCEC_TS_DIRECT);
    end else if (wr_go && idx == `SCCEC_IDX_CHRCTL) begin
      detect_convention_char_q <= pwdata[`SCCEC_CC_DETECT];
      // software restores the flag per card.
      convention_direct_flag_q <= pwdata[`SCCEC_CC_DIRECT];
    end
  end

  // divide by select plus one, then toggle for the card clock.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q    <= 6'h00;
      div_lim_q    <= CLK_RST[5:0];
      etu_div_tick <= 1'b0;
      card_clk     <= 1'b0;
    end else if (div_cnt_q >= div_lim_q) begin
      div_cnt_q    <= 6'h00;
      // new limit loads only at wrap.
      div_lim_q    <= div_lim_new;
      etu_div_tick <= 1'b1;
      card_clk     <= ~card_clk;
    end else begin
      div_cnt_q    <= div_cnt_q + 6'h01;
      etu_div_tick <= 1'b0;
    end
  end

  // The pin is asynchronous to clk_sys; only the second stage is read.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_meta_q <= 1'b1;
      io_sync_q <= 1'b1;
    end else begin
      io_meta_q <= io_in;
      io_sync_q <= io_meta_q;
    end
  end

  // Half-ETU counter from the start bit edge. The start edge is not
  // aligned to the ETU grid, so each point may land up to a half ETU
  // early; the receiver is expected to align its start pulse.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q     <= 1'b0;
      dir_tx_q   <= 1'b0;
      half_cnt_q <= 5'h00;
    end else if (rx_start || tx_start) begin
      busy_q     <= 1'b1;
      dir_tx_q   <= tx_start;
      half_cnt_q <= 5'h00;
    end else if (brk_point || smp_point) begin
      busy_q     <= 1'b0;
      half_cnt_q <= 5'h00;
    end else if (half_step) begin
      half_cnt_q <= half_cnt_q + 5'h01;
    end
  end

  // Receive path: parity verdict, FIFO write and error latch.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      err_pend_q   <= 1'b0;
      par_err_q    <= 1'b0;
      rx_fifo_wr   <= 1'b0;
      rx_fifo_data <= 8'h00;
    end else begin
      rx_fifo_wr <= 1'b0;
      if (rx_start) begin
        err_pend_q <= 1'b0;
      end
      if (rx_done) begin
        err_pend_q   <= rx_err;
        par_err_q    <= rx_err;
        rx_fifo_data <= rx_data;
        // drop bad byte in T=0 when discarding.
        // convention character is stored like any byte.
        rx_fifo_wr   <= ~(discard_en & rx_err);
      end
    end
  end

  // Break generation toward the card.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      brk_q     <= 1'b0;
      brk_cnt_q <= 3'h0;
    end else if (brk_point && err_pend_q && brk_gen_en) begin
      brk_q     <= 1'b1;
      brk_cnt_q <= brk_len;
    end else if (brk_q && etu_half_tick) begin
      // release the line after the length.
      if (brk_cnt_q == 3'h1) begin
        brk_q <= 1'b0;
      end
      brk_cnt_q <= brk_cnt_q - 3'h1;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_out <= 1'b0;
      io_oe  <= 1'b0;
    end else begin
      io_out <= 1'b0;
      io_oe  <= brk_q;
    end
  end

  // Transmit side: parity out, card Break sampling and resend request.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_parity  <= 1'b0;
      tx_resend  <= 1'b0;
      card_brk_q <= 1'b0;
    end else begin
      tx_parity <= (^tx_data) ^ parity_control_q[`SCCEC_PC_INJECT];
      tx_resend <= 1'b0;
      if (tx_start) begin
        card_brk_q <= 1'b0;
      end
      // Only our own characters are watched for a card Break; during
      // reception it is the device that breaks the line.
      // detect card Break in T=0.
      if (smp_point && !io_sync_q && brk_det_en) begin
        card_brk_q <= 1'b1;
        tx_resend  <= resend_en;
      end
    end
  end

  // The flag reaches its port one cycle late so the output is a flop.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      convention_direct <= CHR_RST[`SCCEC_CC_DIRECT];
    end else begin
      convention_direct <= convention_direct_flag_q;
    end
  end

endmodule
`default_nettype wire

/* File: sccec_card.sv */
// Behavioural smart card on the open-drain I/O line with a pull-up.
// Assumes half-ETU ticks and the transmit start pulse come from the bench.
`timescale 1ns/1ps
`default_nettype none
module sccec_card (
  input  wire logic clk_sys,
  input  wire logic etu_half_tick,
  input  wire logic tx_start,
  input  wire logic nack,
  input  wire logic io_oe,
  input  wire logic io_out,
  output wire logic io_line
);
  logic [4:0] tc_q;
  logic       pull_q;
  always @(posedge clk_sys) begin
    if (tx_start)
      tc_q <= 5'h00;
    else if (etu_half_tick && tc_q != 5'h1F)
      tc_q <= tc_q + 5'h01;
    // A rejecting card holds the line low across the device's sample point.
    pull_q <= nack && tc_q >= 5'h14 && tc_q < 5'h18;
  end
  assign io_line = !((io_oe && !io_out) || pull_q);
endmodule
`default_nettype wire

/* File: sccec_top_sva.sv */
// Checker for the character control block, seeing only its ports.
// Assumes every register write arrives over the same APB signals.
`timescale 1ns/1ps
`default_nettype none
`include "sccec_map.vh"
module sccec_top_sva #(
  parameter ADDR_W = 20
) (
  input wire logic              clk_sys,
  input wire logic              arst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              etu_half_tick,
  input wire logic              rx_start,
  input wire logic              rx_done,
  input wire logic [7:0]        rx_data,
  input wire logic              rx_parity,
  input wire logic              tx_start,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_parity,
  input wire logic              tx_resend,
  input wire logic              rx_fifo_wr,
  input wire logic [7:0]        rx_fifo_data,
  input wire logic              card_clk,
  input wire logic              etu_div_tick,
  input wire logic              convention_direct,
  input wire logic              io_out,
  input wire logic              io_oe
);
  logic [7:0] pc_q, cc_q;
  logic [5:0] cd_q;
  logic [6:0] g1_q, g2_q;
  logic [4:0] hc_q;
  logic [2:0] bt_q;
  logic [1:0] st_q;
  logic       t1_q, up_q;
  wire        wr = psel && penable && pready && pwrite && !pslverr;
  wire [15:0] ix = paddr[17:2];
  wire        on = !pc_q[6] && !t1_q;
  wire        err = pc_q[0] || (!pc_q[6] && ^{rx_data, rx_parity});
  wire [6:0]  rat = (cd_q == 6'h00) ? 7'h02 : {1'b0, cd_q} + 7'h01;
  wire [2:0]  dur = (cc_q[4:3] == 2'h3) ? 3'h4 : {1'b0, cc_q[4:3]} + 3'h2;
  // Clock periods are only judged two wraps after a divider write, since the
  // new value is allowed to wait for the running period to finish.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= 8'h00;
      cc_q <= 8'h2C;
      cd_q <= 6'h0C;
      t1_q <= 1'b0;
      up_q <= 1'b0;
      st_q <= 2'h2;
      hc_q <= 5'h00;
      bt_q <= 3'h0;
      g1_q <= 7'h00;
      g2_q <= 7'h00;
    end else begin
      up_q <= 1'b1;
      if (wr && ix == `SCCEC_IDX_PARCTL)
        pc_q <= pwdata[7:0];
      if (wr && ix == `SCCEC_IDX_MODE)
        t1_q <= pwdata[0];
      if (wr && ix == `SCCEC_IDX_CHRCTL)
        cc_q <= pwdata[7:0];
      else if (rx_done)
        cc_q[6] <= 1'b0;
      if (wr && ix == `SCCEC_IDX_CLKDIV) begin
        cd_q <= pwdata[5:0];
        st_q <= 2'h2;
      end else if (etu_div_tick && st_q != 2'h0)
        st_q <= st_q - 2'h1;
      hc_q <= (rx_start || tx_start) ? 5'h00 : hc_q + {4'h0, etu_half_tick && hc_q != 5'h1F};
      bt_q <= io_oe ? bt_q + {2'h0, etu_half_tick} : 3'h0;
      g1_q <= etu_div_tick ? 7'h01 : g1_q + 7'h01;
      g2_q <= $changed(card_clk) ? 7'h01 : g2_q + 7'h01;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_apb; psel && penable && !pready |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("apb answer missing");
  property p_tick; etu_div_tick && st_q == 2'h0 |-> g1_q == rat; endproperty
  a_tick: assert property (p_tick) else $error("divider period wrong");
  property p_cclk; $changed(card_clk) && st_q == 2'h0 |-> g2_q == rat; endproperty
  a_cclk: assert property (p_cclk) else $error("card clock period wrong");
  property p_keep; rx_done && !(on && pc_q[2] && err) |=> rx_fifo_wr && rx_fifo_data == $past(rx_data); endproperty
  a_keep: assert property (p_keep) else $error("byte not stored");
  property p_drop; rx_done && on && pc_q[2] && err |=> !rx_fifo_wr; endproperty
  a_drop: assert property (p_drop) else $error("bad byte stored");
  property p_conv; rx_done && cc_q[6] |-> ##2 convention_direct == $past(rx_data == `SCCEC_TS_DIRECT, 2); endproperty
  a_conv: assert property (p_conv) else $error("convention wrong");
  property p_txpar; up_q |-> tx_parity == $past(^tx_data ^ pc_q[1]); endproperty
  a_txpar: assert property (p_txpar) else $error("tx parity wrong");
  property p_brkon; $rose(io_oe) |-> hc_q == `SCCEC_HALF_BRK_AT && on && !pc_q[5]; endproperty
  a_brkon: assert property (p_brkon) else $error("break start wrong");
  property p_brklen; $fell(io_oe) |-> bt_q == dur && !io_out; endproperty
  a_brklen: assert property (p_brklen) else $error("break length wrong");
  property p_resend; tx_resend |-> hc_q == `SCCEC_HALF_SAMPLE_AT && !t1_q && !pc_q[4] && pc_q[3]; endproperty
  a_resend: assert property (p_resend) else $error("resend wrong");
endmodule
bind sccec_top sccec_top_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

/* File: tb.sv */
// Self-checking bench: registers, card clock, receive checks and breaks.
// Assumes the card model drives the I/O line and ticks come from here.
`timescale 1ns/1ps
`default_nettype none
`include "sccec_map.vh"
module tb;
  logic        clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [19:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, etu_half_tick = 0, rx_start = 0, rx_done = 0;
  logic        rx_parity = 0, tx_start = 0, tx_parity, tx_resend, rx_fifo_wr;
  logic        card_clk, etu_div_tick, convention_direct, io_in, io_out, io_oe;
  logic        nack = 0, bad, md, err;
  logic [7:0]  rx_data = 0, tx_data = 0, rx_fifo_data, d, p;
  logic [1:0]  tc = 0;
  logic [32:0] rq[$];
  logic [7:0]  fq[$];
  logic [7:0]  sv[4] = '{8'h00, 8'h01, 8'h05, 8'h0C};
  logic [7:0]  pct[8] = '{8'h00, 8'h04, 8'h45, 8'h01, 8'h21, 8'h05, 8'h01, 8'h05};
  logic [7:0]  ptx[4] = '{8'h08, 8'h18, 8'h0A, 8'h08};
  integer      err_count = 0, comparisons = 0, seed, i, n, rs = 0, saw = 0;
  sccec_top #(.ADDR_W(20)) dut (.*);
  sccec_card card (.clk_sys, .etu_half_tick, .tx_start, .nack, .io_oe, .io_out, .io_line(io_in));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tc <= tc + 2'h1;
    etu_half_tick <= (tc == 2'h3);
  end
  task chk(input string nm, input logic [32:0] s, input logic [32:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    if (rq.size() != 0 || fq.size() != 0)
      err_count++;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [7:0] v, input logic [32:0] e);
    rq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, a, 2'h0};
    pwdata <= {24'h0, v};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (pready === 1'b1)
      chk("apb", {pslverr, prdata}, rq.pop_front());
    if (rx_fifo_wr === 1'b1 && fq.size() == 0)
      chk("fifo_wr", 1, 0);
    else if (rx_fifo_wr === 1'b1)
      chk("fifo", rx_fifo_data, fq.pop_front());
    if (io_oe === 1'b1)
      saw <= saw + 1;
    if (tx_resend === 1'b1)
      rs <= rs + 1;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    end_sim;
  end
  initial begin
    seed = 94707;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    apb(0, `SCCEC_IDX_CLKDIV, 8'h00, 33'h0000000C);
    apb(0, `SCCEC_IDX_PARCTL, 8'h00, 33'h0);
    apb(0, `SCCEC_IDX_CHRCTL, 8'h00, 33'h0000002C);
    apb(1, 16'hFE30, 8'h5A, {1'b1, 32'h0});
    for (i = 0; i < 4; i++) begin
      apb(1, `SCCEC_IDX_CLKDIV, sv[i], 33'h0);
      repeat (60) @(posedge clk_sys);
      @(card_clk);
      bad = card_clk;
      n = 0;
      do begin
        @(posedge clk_sys);
        #1;
        n++;
      end while (card_clk === bad);
      @(posedge clk_sys);
      chk("ratio", n, (sv[i] == 0 ? 1 : sv[i]) + 1);
    end
    for (i = 0; i < 8; i++) begin
      p = pct[i];
      md = (i == 7);
      bad = i == 0 || $random(seed) & 1;
      d = (i == 0) ? 8'h3B : (i == 1) ? 8'h03 : 8'($random(seed));
      err = p[0] || (!p[6] && bad);
      apb(1, `SCCEC_IDX_PARCTL, p, 33'h0);
      apb(1, `SCCEC_IDX_MODE, {7'h0, md}, 33'h0);
      apb(1, `SCCEC_IDX_CHRCTL, {1'b0, i < 2, 1'b1, 2'(i + 1), 3'h0}, 33'h0);
      @(posedge clk_sys iff etu_half_tick);
      rx_start <= 1'b1;
      @(posedge clk_sys);
      rx_start <= 1'b0;
      repeat (72) @(posedge clk_sys);
      rx_data <= d;
      rx_parity <= ^d ^ bad;
      rx_done <= 1'b1;
      if (!(err && !md && !p[6] && p[2]))
        fq.push_back(d);
      n = saw;
      @(posedge clk_sys);
      rx_done <= 1'b0;
      repeat (60) @(posedge clk_sys);
      chk("break", saw != n, err && !md && !p[6] && !p[5]);
      if (i < 2)
        apb(0, `SCCEC_IDX_CHRCTL, 8'h00, {27'h0, i == 0, 2'(i + 1), 3'h4});
    end
    apb(1, `SCCEC_IDX_MODE, 8'h00, 33'h0);
    for (i = 0; i < 4; i++) begin
      apb(1, `SCCEC_IDX_PARCTL, ptx[i], 33'h0);
      nack <= (i != 3);
      n = rs;
      @(posedge clk_sys iff etu_half_tick);
      tx_data <= 8'($random(seed));
      tx_start <= 1'b1;
      @(posedge clk_sys);
      tx_start <= 1'b0;
      repeat (120) @(posedge clk_sys);
      chk("resend", rs - n, i == 0 || i == 2);
    end
    end_sim;
  end
endmodule
`default_nettype wire
